//--- pdmc_cpu_model.sv
/*
  pdmc_cpu_model: cpu core, interrupt sources and external pins.
  Assumes the controller's system clock; all changes just after a rising edge.
*/
`timescale 1ns/10ps
module pdmc_cpu_model (
  input  wire logic  i_clk,
  output logic       o_sleep_req,
  output logic       o_imask,
  output logic [7:0] o_irq,
  output logic       o_periph_irq,
  output logic       o_nmi,
  output logic       o_init_n,
  output logic       o_hw_standby_pin_n_n
);
  // idle levels at time zero
  initial begin
    o_sleep_req  = 1'b0;
    o_imask      = 1'b0;
    o_irq        = 8'h00;
    o_periph_irq = 1'b0;
    o_nmi        = 1'b0;
    o_init_n     = 1'b1;
    o_hw_standby_pin_n_n     = 1'b1;
  end
  // sleep instruction: one-cycle pulse with the mask level of the moment
  task automatic do_sleep(input logic m);
    @(posedge i_clk);
    o_sleep_req <= 1'b1;
    o_imask     <= m;
    @(posedge i_clk);
    o_sleep_req <= 1'b0;
  endtask
  // request levels and pins; init pin is held low by the caller while clock settles
  task automatic put(input logic [7:0] q, input logic p, input logic n, input logic r, input logic s);
    @(posedge i_clk);
    o_irq        <= q;
    o_periph_irq <= p;
    o_nmi        <= n;
    o_init_n     <= r;
    o_hw_standby_pin_n_n     <= s;
  endtask
endmodule

//--- pdmc_pkg.sv
/*
  pdmc_pkg: constants and types shared by the power-down mode controller.
  Assumes a 250 MHz system clock and a 32-bit APB register bus.
*/
package pdmc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PDMC_SYSCTL_OFS = 16'hFFC4; // system_control
  localparam logic [15:0] PDMC_PINCTL_OFS = 16'hFFC8; // wake source control
  localparam logic [15:0] PDMC_STATUS_OFS = 16'hFFCC; // mode status
  localparam logic [7:0]  PDMC_SYSCTL_RST = 8'h09;
  localparam logic [7:0]  PDMC_PINCTL_RST = 8'h00;

  // ----------------------------------------------------------------
  // system_control field positions
  // ----------------------------------------------------------------
  localparam int PDMC_STANDBY_SELECT_POS  = 7;
  localparam int PDMC_STS_LSB   = 4;
  localparam int PDMC_XINIT_POS = 3;
  localparam int PDMC_NONMASKABLE_EDGE_SELECT_POS = 2;
  localparam int PDMC_HIE_POS   = 1;
  localparam int PDMC_ONCHIP_RAM_ENABLE_POS  = 0;

  // pin control: bit 0 flash variant select, bits 7..4 line3/4/5/7 enables
  localparam int PDMC_FLASH_POS = 0;
  localparam int PDMC_L3E_POS   = 4;

  // ----------------------------------------------------------------
  // settling counts in states (system clock cycles)
  // ----------------------------------------------------------------
  localparam logic [17:0] PDMC_SETTLE_8K   = 18'h02000;
  localparam logic [17:0] PDMC_SETTLE_16K  = 18'h04000;
  localparam logic [17:0] PDMC_SETTLE_32K  = 18'h08000;
  localparam logic [17:0] PDMC_SETTLE_64K  = 18'h10000;
  localparam logic [17:0] PDMC_SETTLE_128K = 18'h20000;
  localparam logic [17:0] PDMC_SETTLE_1K   = 18'h00400;
  localparam logic [17:0] PDMC_SETTLE_ONE  = 18'h00001;

  typedef enum {
    PDMC_RUN,
    PDMC_SLEEP,
    PDMC_SWSTBY,
    PDMC_SETTLE,
    PDMC_HWSTBY,
    PDMC_INIT
  } pdmc_state_t;

endpackage

//--- pdmc_power_down_ctrl.sv
/*
  pdmc_power_down_ctrl: sleep, software standby and hardware standby control.
  Assumes a CPU that pulses a sleep request, interrupt sources on the system
  clock, external pins that are asynchronous, and an APB master.
  Interrupt request levels arrive already qualified by their enable bits.
  The system clock keeps running into this block while the chip-level clock
  is reported stopped, so the settle counter can run.
*/
// Behaviour
// - sleep request enters sleep if standby_select is 0, else software standby
// - standby_select survives an interrupt wake; only a software write clears it
// - settle codes 000..011 give 8192, 16384, 32768, 65536 states
// - code 100 gives 131072; 101 gives 1024 on flash, else 131072
// - during settling oscillator runs while CPU and peripherals stay held
// - sleep halts CPU, keeps its registers, peripherals keep running
// - enabled interrupt in sleep ends sleep and starts interrupt handling
// - disabled module interrupts never wake; masked CPU wakes only by NMI (lines 0,1,2,6 still wake a masked CPU from software standby)
// - reset pin low in sleep goes straight to reset state
// - standby pin low in sleep or software standby enters hardware standby
// - software standby stops clock, halts all, initialises peripheral registers
// - NMI or lines 0,1,2,6 wake standby after the selected settle count
// - reset low in standby starts oscillator; high starts reset handling
// - I/O ports hold their state during software standby
// - NMI edge select: 0 falling edge, 1 rising edge
`timescale 1ns/10ps
module pdmc_power_down_ctrl
  import pdmc_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [15:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // cpu side
  input  wire logic        I_SLEEP_REQ,
  input  wire logic        I_CPU_IMASK,
  input  wire logic [7:0]  I_IRQ_REQ,
  input  wire logic        I_PERIPH_IRQ,
  // external pins
  input  wire logic        I_NMI_PIN,
  input  wire logic        I_CHIP_INIT_PIN_N,
  input  wire logic        I_HW_STANDBY_PIN_N,
  // power control
  output logic             O_CPU_HALT,
  output logic             O_PERIPH_HALT,
  output logic             O_PERIPH_INIT,
  output logic             O_CLK_STOP,
  output logic             O_OSC_EN,
  output logic             O_PORT_HOLD,
  output logic             O_PORT_HIZ,
  output logic             O_INT_START,
  output logic             O_NMI_EVENT,
  output logic             O_RESET_OUT,
  output logic [7:0]       O_LINE_ENABLES
);

  // carrier to the settle timer
  pdmc_settle_if st ();

  // settling counter, started by a standby wake
  pdmc_settle_timer u_timer (
    .i_clk (I_CLK_SYS),
    .i_rst (I_RST),
    .st    (st)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic       nmi_prev_reg;

  // two stages for nmi, init and standby pins
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      pin_meta_reg <= 3'h6;
      pin_sync_reg <= 3'h6;
      nmi_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {I_HW_STANDBY_PIN_N, I_CHIP_INIT_PIN_N, I_NMI_PIN};
      pin_sync_reg <= pin_meta_reg;
      nmi_prev_reg <= pin_sync_reg[0];
    end
  end

  // synchronised pin levels and the detected nmi edge
  logic nmi_s;
  logic init_n_s;
  logic hw_standby_pin_n_n_s;
  logic nmi_edge;
  // only the second stage is read by logic
  assign nmi_s    = pin_sync_reg[0];
  assign init_n_s = pin_sync_reg[1];
  assign hw_standby_pin_n_n_s = pin_sync_reg[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // register state and apb access decode
  logic [7:0] sysctl_reg;
  logic [7:0] sysctl_next;
  logic [7:0] pinctl_reg;
  logic [7:0] pinctl_next;
  logic       xinit_next;
  logic       wr_en;
  logic       rd_en;
  logic       hit;

  // transfers act in the access phase
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;
  assign hit   = (I_PADDR == PDMC_SYSCTL_OFS) || (I_PADDR == PDMC_PINCTL_OFS) ||
                 (I_PADDR == PDMC_STATUS_OFS);

  // mode state
  pdmc_state_t state_reg;
  pdmc_state_t state_next;

  // nmi edges of both polarities
  logic nmi_rise;
  logic nmi_fall;
  assign nmi_rise = nmi_s && !nmi_prev_reg;
  assign nmi_fall = !nmi_s && nmi_prev_reg;

  // nmi edge per selected polarity: 0 falling, 1 rising
  assign nmi_edge = sysctl_reg[PDMC_NONMASKABLE_EDGE_SELECT_POS] ? nmi_rise : nmi_fall;

  // register writes; init flag set by chip reset from pin, read-only
  always_comb begin
    sysctl_next = sysctl_reg;
    pinctl_next = pinctl_reg;
    xinit_next  = sysctl_reg[PDMC_XINIT_POS];
    if (wr_en && I_PADDR == PDMC_SYSCTL_OFS) begin
      sysctl_next = I_PWDATA[7:0];    // only software may clear standby_select
    end
    if (wr_en && I_PADDR == PDMC_PINCTL_OFS) begin
      pinctl_next = I_PWDATA[7:0];
    end
    if (state_reg == PDMC_INIT) begin
      xinit_next = 1'b1;
    end
    sysctl_next[PDMC_XINIT_POS] = xinit_next;
  end

  // register storage; reset values from the package
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      sysctl_reg <= PDMC_SYSCTL_RST;
      pinctl_reg <= PDMC_PINCTL_RST;
    end else begin
      sysctl_reg <= sysctl_next;
      pinctl_reg <= pinctl_next;
    end
  end

  // read mux, registered data, zero-wait answer
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  // read data is loaded in the setup phase
  always_comb begin
    prdata_next = prdata_reg;
    if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      unique case (I_PADDR)
        PDMC_SYSCTL_OFS: prdata_next = {24'h000000, sysctl_reg};
        PDMC_PINCTL_OFS: prdata_next = {24'h000000, pinctl_reg};
        PDMC_STATUS_OFS: prdata_next = {28'h0000000, st.busy, 3'(state_reg)};
        default:         prdata_next = 32'h00000000;
      endcase
    end
  end

  // read data holds until the next read setup
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // apb answer: zero wait states, error on unmapped offsets
  assign O_PRDATA  = prdata_reg;
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = (wr_en || rd_en) && !hit;

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  // wake qualification; mask level held from the sleep request
  logic sleep_wake;
  logic hw_standby_pin_n_wake;
  logic imask_at_sleep_reg;
  logic imask_next;
  logic int_start_next;
  logic int_start_reg;

  // masked cpu or disabled module requests never wake
  assign sleep_wake = nmi_edge || (!imask_at_sleep_reg && ((|I_IRQ_REQ) || I_PERIPH_IRQ));
  // standby wake only by nmi or lines 0,1,2,6
  assign hw_standby_pin_n_wake  = nmi_edge || I_IRQ_REQ[0] || I_IRQ_REQ[1] || I_IRQ_REQ[2] || I_IRQ_REQ[6];

  // next mode; the standby pin overrides every other source
  always_comb begin
    state_next     = state_reg;
    imask_next     = imask_at_sleep_reg;
    int_start_next = 1'b0;
    st.start       = 1'b0;
    st.abort       = 1'b0;
    st.code        = sysctl_reg[PDMC_STS_LSB +: 3];
    st.flash       = pinctl_reg[PDMC_FLASH_POS];
    if (!hw_standby_pin_n_n_s) begin
      state_next = PDMC_HWSTBY;
      st.abort   = 1'b1;
    end else begin
      unique case (state_reg)
        PDMC_RUN: begin
          if (!init_n_s) begin
            state_next = PDMC_INIT;
          end else if (I_SLEEP_REQ) begin
            imask_next = I_CPU_IMASK;
            state_next = sysctl_reg[PDMC_STANDBY_SELECT_POS] ? PDMC_SWSTBY : PDMC_SLEEP;
          end
        end
        PDMC_SLEEP: begin
          if (!init_n_s) begin
            state_next = PDMC_INIT;
          end else if (sleep_wake) begin
            state_next     = PDMC_RUN;
            int_start_next = 1'b1;
          end
        end
        PDMC_SWSTBY: begin
          if (!init_n_s) begin
            state_next = PDMC_INIT;
          end else if (hw_standby_pin_n_wake) begin
            state_next = PDMC_SETTLE;
            st.start   = 1'b1;
          end
        end
        PDMC_SETTLE: begin
          if (!init_n_s) begin
            state_next = PDMC_INIT;
            st.abort   = 1'b1;
          end else if (st.done) begin
            state_next     = PDMC_RUN;
            int_start_next = 1'b1;
          end
        end
        PDMC_HWSTBY: begin
          if (!init_n_s) begin
            state_next = PDMC_INIT;
          end
        end
        PDMC_INIT: begin
          if (init_n_s) begin
            state_next = PDMC_RUN;                  // reset handling begins
          end
        end
      endcase
    end
  end

  // mode registers
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_reg          <= PDMC_RUN;
      imask_at_sleep_reg <= 1'b0;
      int_start_reg      <= 1'b0;
    end else begin
      state_reg          <= state_next;
      imask_at_sleep_reg <= imask_next;
      int_start_reg      <= int_start_next;
    end
  end

  // ----------------------------------------------------------------
  // power control outputs
  // ----------------------------------------------------------------
  // states with the clock stopped and peripheral registers reset
  function automatic logic stops_clock(input pdmc_state_t s);
    return (s == PDMC_SWSTBY) || (s == PDMC_HWSTBY);
  endfunction

  // software standby or its settling phase
  logic in_hw_standby_pin_n;
  assign in_hw_standby_pin_n = (state_reg == PDMC_SWSTBY) || (state_reg == PDMC_SETTLE);

  // sleep halts cpu only; registers kept
  assign O_CPU_HALT     = (state_reg != PDMC_RUN);
  assign O_PERIPH_HALT  = in_hw_standby_pin_n || (state_reg == PDMC_HWSTBY) || (state_reg == PDMC_INIT);
  assign O_PERIPH_INIT  = stops_clock(state_reg);
  assign O_CLK_STOP     = stops_clock(state_reg);
  assign O_OSC_EN       = !O_CLK_STOP;
  assign O_PORT_HOLD    = in_hw_standby_pin_n;
  assign O_PORT_HIZ     = (state_reg == PDMC_HWSTBY);
  assign O_INT_START    = int_start_reg;
  assign O_NMI_EVENT    = nmi_edge;
  assign O_RESET_OUT    = (state_reg == PDMC_INIT) || (state_reg == PDMC_HWSTBY);
  assign O_LINE_ENABLES = {pinctl_reg[7:4], 4'h0};

endmodule

//--- pdmc_props.sv
/*
  pdmc_props: timing checks on the mode outputs of the power-down controller.
  Assumes it is bound into pdmc_power_down_ctrl and sees its ports only.
*/
`timescale 1ns/10ps
module pdmc_props (
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST,
  input wire logic       I_SLEEP_REQ,
  input wire logic [7:0] I_IRQ_REQ,
  input wire logic       I_PERIPH_IRQ,
  input wire logic       I_CHIP_INIT_PIN_N,
  input wire logic       I_HW_STANDBY_PIN_N,
  input wire logic       O_CPU_HALT,
  input wire logic       O_PERIPH_HALT,
  input wire logic       O_PERIPH_INIT,
  input wire logic       O_CLK_STOP,
  input wire logic       O_OSC_EN,
  input wire logic       O_PORT_HOLD,
  input wire logic       O_PORT_HIZ,
  input wire logic       O_INT_START,
  input wire logic       O_NMI_EVENT,
  input wire logic       O_RESET_OUT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  // sleeping with no wake source present
  sequence quiet_s;
    O_CPU_HALT && !O_PERIPH_HALT && I_IRQ_REQ == 8'h00 && !I_PERIPH_IRQ && !O_NMI_EVENT
      && I_CHIP_INIT_PIN_N && I_HW_STANDBY_PIN_N;
  endsequence
  sequence init_low_s;
    $fell(I_CHIP_INIT_PIN_N) ##1 !I_CHIP_INIT_PIN_N [*3];
  endsequence
  sequence hw_standby_pin_n_low_s;
    $fell(I_HW_STANDBY_PIN_N) ##1 !I_HW_STANDBY_PIN_N [*3];
  endsequence
  sequence settle_s;
    $fell(O_CLK_STOP) && !O_RESET_OUT;
  endsequence
  // sleep, or settling after a standby wake
  sequence osc_on_s;
    (O_CPU_HALT && !O_PERIPH_HALT) || (O_PORT_HOLD && !O_PERIPH_INIT);
  endsequence
  // everything held and initialised in software standby
  sequence held_s;
    O_PERIPH_INIT && O_PERIPH_HALT && O_CPU_HALT && O_PORT_HOLD;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sleep_halt_a: assert property (I_SLEEP_REQ && !O_CPU_HALT |=> O_CPU_HALT)
    else $error("cpu not halted after sleep request");
  osc_clock_a: assert property (osc_on_s |-> O_OSC_EN)
    else $error("oscillator stopped in sleep or settling");
  hw_standby_pin_n_held_a: assert property (O_CLK_STOP && !O_PORT_HIZ |-> held_s)
    else $error("software standby outputs wrong");
  settle_hold_a: assert property (settle_s |-> O_CPU_HALT && O_PERIPH_HALT && O_PORT_HOLD)
    else $error("settling released cpu or ports early");
  wake_int_a: assert property (O_INT_START |-> $past(O_CPU_HALT) && !O_CPU_HALT)
    else $error("interrupt start without wake");
  no_wake_a: assert property (quiet_s |=> O_CPU_HALT)
    else $error("sleep left without a wake source");
  init_pin_a: assert property (init_low_s |-> O_RESET_OUT)
    else $error("init pin low did not reach reset");
  hw_hw_standby_pin_n_a: assert property (hw_standby_pin_n_low_s |-> O_PORT_HIZ && O_CLK_STOP && O_RESET_OUT)
    else $error("standby pin low did not reach hardware standby");
endmodule

bind pdmc_power_down_ctrl pdmc_props i_pdmc_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_SLEEP_REQ(I_SLEEP_REQ), .I_IRQ_REQ(I_IRQ_REQ),
  .I_PERIPH_IRQ(I_PERIPH_IRQ), .I_CHIP_INIT_PIN_N(I_CHIP_INIT_PIN_N),
  .I_HW_STANDBY_PIN_N(I_HW_STANDBY_PIN_N), .O_CPU_HALT(O_CPU_HALT), .O_PERIPH_HALT(O_PERIPH_HALT),
  .O_PERIPH_INIT(O_PERIPH_INIT), .O_CLK_STOP(O_CLK_STOP), .O_OSC_EN(O_OSC_EN),
  .O_PORT_HOLD(O_PORT_HOLD), .O_PORT_HIZ(O_PORT_HIZ), .O_INT_START(O_INT_START),
  .O_NMI_EVENT(O_NMI_EVENT), .O_RESET_OUT(O_RESET_OUT));

//--- pdmc_settle_if.sv
/*
  pdmc_settle_if: connection between the mode controller and its settle timer.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/10ps
interface pdmc_settle_if;
  import pdmc_pkg::*;
  logic        start;   // one-cycle pulse: load and begin counting
  logic        abort;   // stop counting at once
  logic [2:0]  code;    // settle-select code sampled at start
  logic        flash;   // flash variant decode
  logic        done;    // one-cycle pulse at terminal count
  logic        busy;

  modport ctrl (output start, output abort, output code, output flash, input done, input busy);
  modport timer (input start, input abort, input code, input flash, output done, output busy);
endinterface

//--- pdmc_settle_timer.sv
/*
  pdmc_settle_timer: counts settling states after the oscillator restarts.
  Assumes start and code come from logic on the same clock.
*/
`timescale 1ns/10ps
module pdmc_settle_timer
  import pdmc_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  pdmc_settle_if.timer  st
);

  logic [17:0] cnt_reg;
  logic [17:0] cnt_next;
  logic        busy_reg;
  logic        busy_next;
  logic        done_reg;
  logic        done_next;

  // ----------------------------------------------------------------
  // code to count decode
  // ----------------------------------------------------------------
  function automatic logic [17:0] settle_count(input logic [2:0] c, input logic fl);
    logic [17:0] n;
    n = PDMC_SETTLE_128K;
    unique case (c)
      3'h0: n = PDMC_SETTLE_8K;
      3'h1: n = PDMC_SETTLE_16K;
      3'h2: n = PDMC_SETTLE_32K;
      3'h3: n = PDMC_SETTLE_64K;
      3'h4: n = PDMC_SETTLE_128K;
      3'h5: n = fl ? PDMC_SETTLE_1K : PDMC_SETTLE_128K;
      default: n = PDMC_SETTLE_128K;   // unused codes fall to longest
    endcase
    return n;
  endfunction

  // next-state of the down counter
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (st.abort) begin
      busy_next = 1'b0;
    end else if (st.start) begin
      cnt_next  = settle_count(st.code, st.flash);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == PDMC_SETTLE_ONE) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - PDMC_SETTLE_ONE;
      end
    end
  end

  // counter registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign st.done = done_reg;
  assign st.busy = busy_reg;

endmodule

//--- power_down_mode_controller_tb_top.sv
/*
  power_down_mode_controller_tb_top: self-checking bench for the controller.
  Assumes pdmc_cpu_model on the cpu side and an apb master in this module.
*/
`timescale 1ns/10ps
module power_down_mode_controller_tb_top;
  import pdmc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, sreq, imask, pirq, nmi, init_n, hw_standby_pin_n_n;
  logic [7:0]  irq, lines;
  logic        halt, phalt, pinit, cstop, osc, hold, hiz, ints, nmiev, rsto;
  int          miscompares = 0, num_checks = 0, n;
  always #2 clk = ~clk;

  pdmc_power_down_ctrl i_pdmc_power_down_ctrl (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SLEEP_REQ(sreq), .I_CPU_IMASK(imask),
    .I_IRQ_REQ(irq), .I_PERIPH_IRQ(pirq), .I_NMI_PIN(nmi), .I_CHIP_INIT_PIN_N(init_n),
    .I_HW_STANDBY_PIN_N(hw_standby_pin_n_n), .O_CPU_HALT(halt), .O_PERIPH_HALT(phalt), .O_PERIPH_INIT(pinit),
    .O_CLK_STOP(cstop), .O_OSC_EN(osc), .O_PORT_HOLD(hold), .O_PORT_HIZ(hiz), .O_INT_START(ints),
    .O_NMI_EVENT(nmiev), .O_RESET_OUT(rsto), .O_LINE_ENABLES(lines));
  pdmc_cpu_model i_pdmc_cpu_model (.i_clk(clk), .o_sleep_req(sreq), .o_imask(imask), .o_irq(irq),
    .o_periph_irq(pirq), .o_nmi(nmi), .o_init_n(init_n), .o_hw_standby_pin_n_n(hw_standby_pin_n_n));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // cycles until the interrupt start pulse
  task automatic wait_int(input int lim);
    n = 0;
    do begin @(negedge clk); n++; end while (ints !== 1'b1 && n < lim);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(PDMC_SYSCTL_OFS, 32'h09);
    rd(PDMC_PINCTL_OFS, 32'h00);
    apb(1'b1, PDMC_SYSCTL_OFS, 32'h00);
    rd(PDMC_SYSCTL_OFS, 32'h08);
    apb(1'b0, 16'hFFD0, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(1'b1, PDMC_PINCTL_OFS, 32'hF1);
    @(negedge clk);
    chk(lines, 8'hF0);
    $display("test regs done");
  endtask
  task automatic t_sleep;
    for (int k = 0; k < 2; k++) begin
      i_pdmc_cpu_model.do_sleep(1'b0);
      @(negedge clk);
      chk({halt, phalt, cstop}, 3'b100);
      i_pdmc_cpu_model.put(k ? 8'h08 : 8'h00, ~k[0], 1'b0, 1'b1, 1'b1);
      wait_int(10);
      chk(n, 2);
      i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    end
    $display("test sleep done");
  endtask
  task automatic t_mask;
    apb(1'b1, PDMC_SYSCTL_OFS, 32'h05);
    i_pdmc_cpu_model.do_sleep(1'b1);
    i_pdmc_cpu_model.put(8'h01, 1'b1, 1'b0, 1'b1, 1'b1);
    repeat (20) @(negedge clk);
    chk(halt, 1'b1);
    i_pdmc_cpu_model.put(8'h01, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (3) @(negedge clk);
    chk(nmiev, 1'b1);
    wait_int(10);
    chk(ints, 1'b1);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    $display("test mask done");
  endtask
  task automatic t_hw_standby_pin_n;
    logic [7:0] src [4] = '{8'h01, 8'h02, 8'h04, 8'h40};
    apb(1'b1, PDMC_PINCTL_OFS, 32'h01);
    for (int k = 0; k < 4; k++) begin
      // code 101 on flash for lines 0..2, code 000 for line 6; external clock assumed
      apb(1'b1, PDMC_SYSCTL_OFS, (k == 3) ? 32'h85 : 32'hD5);
      i_pdmc_cpu_model.do_sleep(1'b0);
      i_pdmc_cpu_model.put(8'h08, 1'b0, 1'b0, 1'b1, 1'b1);
      repeat (20) @(negedge clk);
      chk({cstop, pinit, hold, osc}, 4'b1110);
      rd(PDMC_STATUS_OFS, 32'h02);
      i_pdmc_cpu_model.put(src[k], 1'b0, 1'b0, 1'b1, 1'b1);
      wait_int(9000);
      chk((n >= ((k == 3) ? 8192 : 1024)) && (n <= ((k == 3) ? 8196 : 1028)), 1'b1);
      i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
      rd(PDMC_SYSCTL_OFS, (k == 3) ? 32'h8D : 32'hDD);
    end
    $display("test standby done");
  endtask
  task automatic t_pins;
    apb(1'b1, PDMC_SYSCTL_OFS, 32'h0D);
    i_pdmc_cpu_model.do_sleep(1'b0);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    chk(rsto, 1'b1);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    chk(halt, 1'b0);
    apb(1'b1, PDMC_SYSCTL_OFS, 32'h8D);
    i_pdmc_cpu_model.do_sleep(1'b0);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    repeat (5) @(negedge clk);
    chk({hiz, rsto, cstop}, 3'b111);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (10) @(negedge clk);
    i_pdmc_cpu_model.put(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (5) @(negedge clk);
    chk({halt, rsto}, 2'b00);
    $display("test pins done");
  endtask

  // main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sleep();
    t_mask();
    t_hw_standby_pin_n();
    t_pins();
    give_verdict();
  end
  // watchdog well beyond the longest settling sequence
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
